// *** design/usb_epcs_defines.svh ***
// Constants for the USB endpoint control and status block
// Summary of operation
// - Stall clear acts on selected direction only
// - Status clear resets exactly the masked bits
// - Control bit switches controller to device mode
// - Report bytes held in each receive FIFO
// - Zero-length packet is valid, count zero
// - No FIFO load while packet pending
// - Send trigger carries a transaction type
// - Send refused with flag while transmitting
// - Toggle reset per direction, not endpoint zero
// - Three receive, three transmit DMA channels mappable
// - DMA disable per direction, other bits ignored
// - DMA enable per direction selects access mode
// - Host IN endpoint flag set
// - Host OUT endpoint flag set
// - Host endpoint zero flag set
// - Device OUT endpoint flag set
// - Device IN endpoint flag set
// - Device endpoint zero flag set
// - Status flags stay set until cleared
// - Expose physical FIFO address per endpoint
// - Shared FIFO memory, first part for endpoint zero
// - Auto transmit starts on full packet loaded
// - Auto clear drops packet ready after drain
`ifndef USB_EPCS_DEFINES_SVH
`define USB_EPCS_DEFINES_SVH
// Register byte offsets and pages
`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_RESULT    8'h08
`define OFS_AUTO      8'h0C
`define OFS_EPSTATE   8'h40
`define OFS_DMAMAP    8'h44
`define PAGE_STAT     4'h1
`define PAGE_AVAIL    4'h2
`define PAGE_FADDR    4'h3
`define PAGE_DATA     4'h5
// Command word fields
`define CMD_EP        1:0
`define CMD_DIR_IN    4
`define CMD_DIR_OUT   5
`define CMD_OP        11:8
`define CMD_ARG       14:12
// Command codes
`define OP_STALL_SET  4'h1
`define OP_STALL_CLR  4'h2
`define OP_TOGGLE_CLR 4'h3
`define OP_DMA_EN     4'h4
`define OP_DMA_DIS    4'h5
`define OP_SEND       4'h6
`define OP_DMA_MAP    4'h7
// Transaction types
`define XFER_HOST_OUT     3'h0
`define XFER_DEVICE_IN    3'h1
`define XFER_CTRL_IN_LAST 3'h2
`define XFER_CTRL_SETUP   3'h3
`define XFER_CTRL_STATUS  3'h4
// Status bit groups: host bits low half, device bits high half
`define HOST_MASK      32'h0000_3FFF
`define DEV_MASK       32'h03FF_0000
`define HOST_EP0_MASK  32'h0000_000F
`define DEV_EP0_MASK   32'h000F_0000
`define RX_READY_BITS  32'h0010_0080
`define CTRL_RX_BITS   32'h0008_0008
`define TX_PEND_BITS   32'h0200_2000
`define CTRL_TX_BITS   32'h0004_0000
`define TX_NE_BITS     32'h0100_1000
// FIFO memory layout
`define FIFO_TOTAL     13'h1000
`define EP0_FIFO       13'h0040
`define EPN_FIFO       13'h0540
`define MAX_PKT        13'h0040
// Physical FIFO window, arbitrary placement
`define FIFO_PHYS_BASE 32'h4005_0020
`define FIFO_STRIDE    32'h0000_0004
`define REMAP_SUPPORT  1'b1
`endif

// *** design/usb_epcs_pkg.sv ***
// Types for the USB endpoint control and status block
package usb_epcs_pkg;
  typedef logic [2:0]  xfer_t;
  typedef logic [12:0] count_t;
  typedef struct packed {
    logic        evt;
    logic [1:0]  evt_ep;
    logic [31:0] evt_bits;
    logic        rx_done;
    logic [1:0]  rx_ep;
    count_t      rx_len;
    logic        tx_done;
    logic [1:0]  tx_ep;
  } link_event_s;
  typedef struct packed {
    logic       valid;
    logic [1:0] ep;
    xfer_t      xfer;
  } tx_request_s;
  typedef struct packed {
    logic            device_mode;
    logic [3:0]      stall_in;
    logic [3:0]      stall_out;
    logic [3:0]      toggle_in;
    logic [3:0]      toggle_out;
    logic [3:0]      dma_in_en;
    logic [3:0]      dma_out_en;
    logic [3:0][1:0] dma_mode;
    logic [2:0][1:0] rx_chan_ep;
    logic [2:0][1:0] tx_chan_ep;
  } ep_ctrl_s;
endpackage

// *** design/usb_endpoint_control_status.sv ***
// Endpoint control and status logic of the USB controller
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "usb_epcs_defines.svh"
module usb_endpoint_control_status (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Register port
  input  wire logic [7:0]                addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic [31:0]                    rdata,
  // Link side
  input  wire usb_epcs_pkg::link_event_s link_in,
  output usb_epcs_pkg::tx_request_s      tx_req,
  output usb_epcs_pkg::ep_ctrl_s         ep_ctrl
);
  import usb_epcs_pkg::*;

  logic [3:0][31:0] status;
  logic [3:0][31:0] next_status;
  count_t [3:0]     rx_level;
  count_t [3:0]     tx_level;
  logic [3:0]       tx_busy;
  logic [3:0]       auto_tx;
  logic [3:0]       auto_clr;
  logic [1:0]       result;

  // Decode of strobes
  logic       cmd_wr;
  logic [1:0] cmd_ep;
  logic [3:0] cmd_op;
  logic [2:0] cmd_arg;
  logic       cmd_in;
  logic       cmd_out;
  logic       cmd_valid_ep;
  logic       cmd_rx_dir;
  logic [1:0] page_ep;
  logic       stat_wr;
  logic       data_wr;
  logic       data_rd;
  logic [31:0] mode_mask;
  assign cmd_wr       = wr && (addr == `OFS_CMD);
  assign cmd_ep       = wdata[`CMD_EP];
  assign cmd_op       = wdata[`CMD_OP];
  assign cmd_arg      = wdata[`CMD_ARG];
  assign cmd_in       = wdata[`CMD_DIR_IN];
  assign cmd_out      = wdata[`CMD_DIR_OUT];
  assign cmd_valid_ep = (cmd_ep != 2'h0);
  assign cmd_rx_dir   = ep_ctrl.device_mode ? cmd_out : cmd_in;
  assign page_ep      = addr[3:2];
  assign stat_wr      = wr && (addr[7:4] == `PAGE_STAT);
  assign data_wr      = wr && (addr[7:4] == `PAGE_DATA);
  assign data_rd      = rd && (addr[7:4] == `PAGE_DATA);
  assign mode_mask    = ep_ctrl.device_mode ? `DEV_MASK : `HOST_MASK;

  // Transmit start conditions
  logic   fifo_room;
  logic   load_ok;
  logic   auto_go;
  logic   send_go;
  count_t fifo_size;
  assign fifo_size = (page_ep == 2'h0) ? `EP0_FIFO : `EPN_FIFO;
  assign fifo_room = tx_level[page_ep] < fifo_size;
  assign load_ok   = data_wr && !tx_busy[page_ep] && fifo_room;
  assign auto_go   = load_ok && auto_tx[page_ep]
                     && (tx_level[page_ep] == `MAX_PKT - 13'h0001);
  assign send_go   = cmd_wr && (cmd_op == `OP_SEND) && !tx_busy[cmd_ep];

  // Mode and automatic options
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ep_ctrl.device_mode <= 1'b0;
      auto_tx             <= 4'h0;
      auto_clr            <= 4'h0;
    end else if (wr && addr == `OFS_CTRL) begin
      ep_ctrl.device_mode <= wdata[0];
    end else if (wr && addr == `OFS_AUTO) begin
      auto_tx  <= wdata[3:0];
      auto_clr <= wdata[7:4];
    end
  end

  // Stall state per direction
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ep_ctrl.stall_in  <= 4'h0;
      ep_ctrl.stall_out <= 4'h0;
    end else if (cmd_wr && cmd_op == `OP_STALL_SET) begin
      if (cmd_in)  ep_ctrl.stall_in[cmd_ep]  <= 1'b1;
      if (cmd_out) ep_ctrl.stall_out[cmd_ep] <= 1'b1;
    end else if (cmd_wr && cmd_op == `OP_STALL_CLR) begin
      if (cmd_in)  ep_ctrl.stall_in[cmd_ep]  <= 1'b0;
      if (cmd_out) ep_ctrl.stall_out[cmd_ep] <= 1'b0;
    end
  end

  // Data toggles, flipped by the link, forced to zero by command
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ep_ctrl.toggle_in  <= 4'h0;
      ep_ctrl.toggle_out <= 4'h0;
    end else begin
      if (link_in.tx_done && ep_ctrl.device_mode)
        ep_ctrl.toggle_in[link_in.tx_ep] <= ~ep_ctrl.toggle_in[link_in.tx_ep];
      if (link_in.tx_done && !ep_ctrl.device_mode)
        ep_ctrl.toggle_out[link_in.tx_ep] <= ~ep_ctrl.toggle_out[link_in.tx_ep];
      if (link_in.rx_done && ep_ctrl.device_mode)
        ep_ctrl.toggle_out[link_in.rx_ep] <= ~ep_ctrl.toggle_out[link_in.rx_ep];
      if (link_in.rx_done && !ep_ctrl.device_mode)
        ep_ctrl.toggle_in[link_in.rx_ep] <= ~ep_ctrl.toggle_in[link_in.rx_ep];
      if (cmd_wr && cmd_op == `OP_TOGGLE_CLR && cmd_valid_ep) begin
        if (cmd_in)  ep_ctrl.toggle_in[cmd_ep]  <= 1'b0;
        if (cmd_out) ep_ctrl.toggle_out[cmd_ep] <= 1'b0;
      end
    end
  end

  // DMA enables and access modes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ep_ctrl.dma_in_en  <= 4'h0;
      ep_ctrl.dma_out_en <= 4'h0;
      ep_ctrl.dma_mode   <= '0;
    end else if (cmd_wr && cmd_op == `OP_DMA_EN) begin
      if (cmd_in)  ep_ctrl.dma_in_en[cmd_ep]  <= 1'b1;
      if (cmd_out) ep_ctrl.dma_out_en[cmd_ep] <= 1'b1;
      if (cmd_in || cmd_out) ep_ctrl.dma_mode[cmd_ep] <= cmd_arg[1:0];
    end else if (cmd_wr && cmd_op == `OP_DMA_DIS) begin
      if (cmd_in)  ep_ctrl.dma_in_en[cmd_ep]  <= 1'b0;
      if (cmd_out) ep_ctrl.dma_out_en[cmd_ep] <= 1'b0;
    end
  end

  // DMA channel map; endpoint zero and channel three are ignored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ep_ctrl.rx_chan_ep <= {2'h3, 2'h2, 2'h1};
      ep_ctrl.tx_chan_ep <= {2'h3, 2'h2, 2'h1};
    end else if (cmd_wr && cmd_op == `OP_DMA_MAP && cmd_valid_ep
                 && cmd_arg[1:0] != 2'h3 && `REMAP_SUPPORT) begin
      if (cmd_rx_dir)
        ep_ctrl.rx_chan_ep[cmd_arg[1:0]] <= cmd_ep;
      else
        ep_ctrl.tx_chan_ep[cmd_arg[1:0]] <= cmd_ep;
    end
  end

  // Transmit request toward the link
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_req <= '0;
    end else if (send_go) begin
      tx_req <= '{valid: 1'b1, ep: cmd_ep, xfer: cmd_arg};
    end else if (auto_go) begin
      tx_req.valid <= 1'b1;
      tx_req.ep    <= page_ep;
      tx_req.xfer  <= ep_ctrl.device_mode ? `XFER_DEVICE_IN : `XFER_HOST_OUT;
    end else begin
      tx_req.valid <= 1'b0;
    end
  end

  // Transmit busy and loaded byte count per endpoint
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_busy  <= 4'h0;
      tx_level <= '0;
    end else begin
      if (link_in.tx_done) begin
        tx_busy[link_in.tx_ep]  <= 1'b0;
        tx_level[link_in.tx_ep] <= 13'h0000;
      end
      if (load_ok)
        tx_level[page_ep] <= tx_level[page_ep] + 13'h0001;
      if (send_go)
        tx_busy[cmd_ep] <= 1'b1;
      if (auto_go)
        tx_busy[page_ep] <= 1'b1;
    end
  end

  // Refusal indications for send and load
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      result <= 2'h0;
    end else if (cmd_wr && cmd_op == `OP_SEND) begin
      result[0] <= tx_busy[cmd_ep];
    end else if (data_wr) begin
      result[1] <= !load_ok;
    end
  end

  // Receive byte count per endpoint
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_level <= '0;
    end else begin
      if (data_rd && rx_level[page_ep] != 13'h0000)
        rx_level[page_ep] <= rx_level[page_ep] - 13'h0001;
      if (link_in.rx_done)
        rx_level[link_in.rx_ep] <= link_in.rx_len;
    end
  end

  // Sticky status per endpoint; a set in the clear cycle wins
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_stat
      logic [31:0] ep_mask;
      logic [31:0] set_bits;
      logic [31:0] clr_bits;
      logic [31:0] ready_bits;
      logic        drained;
      assign ep_mask    = mode_mask & ((g == 0) ? (`HOST_EP0_MASK | `DEV_EP0_MASK)
                                                : 32'hFFFF_FFFF);
      assign ready_bits = (g == 0) ? `CTRL_RX_BITS : `RX_READY_BITS;
      assign drained    = data_rd && page_ep == g && auto_clr[g]
                          && rx_level[g] == 13'h0001;
      always_comb begin
        set_bits = 32'h0000_0000;
        if (link_in.evt && link_in.evt_ep == g)
          set_bits = set_bits | link_in.evt_bits;
        if (link_in.rx_done && link_in.rx_ep == g)
          set_bits = set_bits | ready_bits;
        if ((send_go && cmd_ep == g) || (auto_go && page_ep == g))
          set_bits = set_bits | ((g == 0) ? `CTRL_TX_BITS : `TX_PEND_BITS);
        if (load_ok && page_ep == g && g != 0)
          set_bits = set_bits | `TX_NE_BITS;
        set_bits = set_bits & ep_mask;
      end
      assign clr_bits = ((stat_wr && page_ep == g) ? wdata : 32'h0000_0000)
                        | (drained ? ready_bits : 32'h0000_0000);
      assign next_status[g] = (status[g] & ~clr_bits) | set_bits;
    end
  endgenerate

  // Status storage
  always_ff @(posedge clk) begin
    if (!rst_b)
      status <= '0;
    else
      status <= next_status;
  end

  // Read data, valid in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr[7:4])
        `PAGE_STAT:  rdata <= status[page_ep];
        `PAGE_AVAIL: rdata <= {15'h0000, |(status[page_ep] & (`RX_READY_BITS
                               | `CTRL_RX_BITS)), 3'h0, rx_level[page_ep]};
        `PAGE_FADDR: rdata <= `FIFO_PHYS_BASE
                              + `FIFO_STRIDE * {30'h0000_0000, page_ep};
        default: begin
          case (addr)
            `OFS_CTRL:    rdata <= {31'h0000_0000, ep_ctrl.device_mode};
            `OFS_RESULT:  rdata <= {30'h0000_0000, result};
            `OFS_AUTO:    rdata <= {24'h0000_00, auto_clr, auto_tx};
            `OFS_EPSTATE: rdata <= {4'h0, tx_busy, ep_ctrl.dma_out_en,
                                    ep_ctrl.dma_in_en, ep_ctrl.toggle_out,
                                    ep_ctrl.toggle_in, ep_ctrl.stall_out,
                                    ep_ctrl.stall_in};
            `OFS_DMAMAP:  rdata <= {20'h0_0000, ep_ctrl.tx_chan_ep,
                                    ep_ctrl.rx_chan_ep};
            default:      rdata <= 32'h0000_0000;
          endcase
        end
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_send_idle;
    cmd_wr && cmd_op == `OP_SEND && !tx_busy[cmd_ep];
  endsequence
  sequence s_full_load;
    load_ok && auto_tx[page_ep] && tx_level[page_ep] == 13'h003F;
  endsequence

  a_send_start: assert property (
    s_send_idle |=> tx_req.valid && tx_req.ep == $past(cmd_ep)
                    && tx_req.xfer == $past(cmd_arg) ##1 !tx_req.valid)
    else $error("send did not start once");
  a_send_refused: assert property (
    cmd_wr && cmd_op == `OP_SEND && tx_busy[cmd_ep] |=> !tx_req.valid && result[0])
    else $error("busy send not refused");
  a_load_blocked: assert property (
    data_wr && tx_busy[page_ep] && !link_in.tx_done
    |=> tx_level[$past(page_ep)] == $past(tx_level[page_ep]) && result[1])
    else $error("load accepted while pending");
  a_auto_start: assert property (
    s_full_load |=> tx_req.valid ##0 tx_busy[$past(page_ep)])
    else $error("auto transmit missed");
  a_status_clear: assert property (
    stat_wr && !link_in.evt && !link_in.rx_done && !data_wr && !cmd_wr
    |=> status[$past(page_ep)] == ($past(status[page_ep]) & ~$past(wdata)))
    else $error("status clear mask wrong");
  a_status_sticky: assert property (
    !stat_wr && !data_rd |=> (($past(status[1]) & ~status[1]) == 32'h0000_0000))
    else $error("status bit dropped");
  a_stall_clear: assert property (
    cmd_wr && cmd_op == `OP_STALL_CLR && cmd_in && !cmd_out
    |=> !ep_ctrl.stall_in[$past(cmd_ep)] && $stable(ep_ctrl.stall_out))
    else $error("stall clear direction wrong");
  a_toggle_ep0: assert property (
    cmd_wr && cmd_op == `OP_TOGGLE_CLR && cmd_ep == 2'h0 && !link_in.tx_done
    && !link_in.rx_done |=> $stable(ep_ctrl.toggle_in) && $stable(ep_ctrl.toggle_out))
    else $error("toggle changed on endpoint zero");
  a_zero_length: assert property (
    link_in.rx_done && link_in.rx_len == 13'h0000 && ep_ctrl.device_mode
    && link_in.rx_ep != 2'h0 |=> rx_level[$past(link_in.rx_ep)] == 13'h0000
    && status[$past(link_in.rx_ep)][20])
    else $error("zero length packet lost");
  a_dma_disable: assert property (
    cmd_wr && cmd_op == `OP_DMA_DIS && (cmd_in || cmd_out)
    |=> (!$past(cmd_in) || !ep_ctrl.dma_in_en[$past(cmd_ep)])
        && (!$past(cmd_out) || !ep_ctrl.dma_out_en[$past(cmd_ep)])
        && $stable(ep_ctrl.dma_mode))
    else $error("dma disable failed");

  // Checks on toggles, DMA, mapping, receive counts, reads, mode switch and transmit busy and limits
  a_toggle_clear: assert property (
    cmd_wr && cmd_op == `OP_TOGGLE_CLR && cmd_valid_ep && cmd_in
    |=> !ep_ctrl.toggle_in[$past(cmd_ep)])
    else $error("toggle not forced to zero");
  a_dma_enable: assert property (
    cmd_wr && cmd_op == `OP_DMA_EN && cmd_in
    |=> ep_ctrl.dma_in_en[$past(cmd_ep)]
        && ep_ctrl.dma_mode[$past(cmd_ep)] == $past(cmd_arg[1:0]))
    else $error("dma enable or mode wrong");
  a_map_channel: assert property (
    cmd_wr && cmd_op == `OP_DMA_MAP && cmd_valid_ep && cmd_rx_dir && cmd_arg[1:0] != 2'h3
    |=> ep_ctrl.rx_chan_ep[$past(cmd_arg[1:0])] == $past(cmd_ep))
    else $error("receive channel not mapped");
  a_map_ep0: assert property (
    cmd_wr && cmd_op == `OP_DMA_MAP && cmd_ep == 2'h0
    |=> $stable(ep_ctrl.rx_chan_ep) && $stable(ep_ctrl.tx_chan_ep))
    else $error("map changed for endpoint zero");
  a_rx_count: assert property (
    link_in.rx_done |=> rx_level[$past(link_in.rx_ep)] == $past(link_in.rx_len))
    else $error("receive count wrong");
  a_auto_clear: assert property (
    data_rd && page_ep != 2'h0 && auto_clr[page_ep] && rx_level[page_ep] == 13'h0001
    && !link_in.rx_done && !link_in.evt
    |=> (status[$past(page_ep)] & `RX_READY_BITS) == 32'h0000_0000)
    else $error("ready flag not cleared after drain");
  a_ep0_limit: assert property (
    data_wr && page_ep == 2'h0 && tx_level[0] == `EP0_FIFO && !link_in.tx_done
    |=> tx_level[0] == `EP0_FIFO && result[1])
    else $error("endpoint zero fifo overfilled");
  a_mode_switch: assert property (
    wr && addr == `OFS_CTRL |=> ep_ctrl.device_mode == $past(wdata[0]))
    else $error("mode switch lost");
  a_fifo_addr: assert property (
    rd && addr[7:4] == `PAGE_FADDR
    |=> rdata == `FIFO_PHYS_BASE + `FIFO_STRIDE * {30'h0000_0000, $past(page_ep)})
    else $error("fifo address wrong");
  a_tx_pending: assert property (
    s_send_idle ##0 (ep_ctrl.device_mode && cmd_ep != 2'h0)
    |=> status[$past(cmd_ep)][25])
    else $error("pending flag not raised");
  a_busy_hold: assert property (
    tx_busy[1] && !(link_in.tx_done && link_in.tx_ep == 2'h1)
    |=> tx_busy[1])
    else $error("busy dropped without completion");
endmodule // usb_endpoint_control_status

// *** dv/usb_link_partner.sv ***
// Behavioural model of the remote USB party on the link side
`timescale 1ns/1ps
module usb_link_partner (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Link side
  input  wire usb_epcs_pkg::tx_request_s tx_req,
  output usb_epcs_pkg::link_event_s      link_in
);
  import usb_epcs_pkg::*;
  int         reply_delay;
  int         cnt;
  logic [1:0] done_ep;
  // Quiet link; idle fields hold inverted values
  initial begin
    reply_delay = 3;
    cnt = 0;
    done_ep = 2'h0;
    link_in = '{1'b0, 2'h3, 32'hFFFF_FFFF, 1'b0, 2'h3, 13'h1FFF, 1'b0, 2'h3};
  end
  // Answer a started transfer after reply_delay cycles
  always @(posedge clk) begin
    link_in.tx_done <= 1'b0;
    link_in.tx_ep <= ~done_ep;
    if (!rst_b) begin
      cnt <= 0;
    end else if (tx_req.valid === 1'b1) begin
      cnt <= reply_delay;
      done_ep <= tx_req.ep;
    end else if (cnt == 1) begin
      link_in.tx_done <= 1'b1;
      link_in.tx_ep <= done_ep;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // One received packet, one cycle long
  task automatic rx_packet(input logic [1:0] ep, input count_t len);
    @(posedge clk);
    link_in.rx_done <= 1'b1;
    link_in.rx_ep <= ep;
    link_in.rx_len <= len;
    @(posedge clk);
    link_in.rx_done <= 1'b0;
    link_in.rx_ep <= ~ep;
    link_in.rx_len <= ~len;
  endtask
  // One status event, one cycle long
  task automatic flag_event(input logic [1:0] ep, input logic [31:0] bits);
    @(posedge clk);
    link_in.evt <= 1'b1;
    link_in.evt_ep <= ep;
    link_in.evt_bits <= bits;
    @(posedge clk);
    link_in.evt <= 1'b0;
    link_in.evt_ep <= ~ep;
    link_in.evt_bits <= ~bits;
  endtask
endmodule // usb_link_partner

// *** dv/tb.sv ***
// Self-checking testbench for the USB endpoint control and status block
`timescale 1ns/1ps
`include "usb_epcs_defines.svh"
module tb;
  import usb_epcs_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  link_event_s link_in;
  tx_request_s tx_req;
  ep_ctrl_s    ep_ctrl;
  int          err_count;
  int          compares;
  int          tx_count;
  int          n0;
  logic [31:0] rv;
  // Design and link partner
  usb_endpoint_control_status u_usb_endpoint_control_status (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link_in(link_in), .tx_req(tx_req), .ep_ctrl(ep_ctrl));
  usb_link_partner u_usb_link_partner (
    .clk(clk), .rst_b(rst_b), .tx_req(tx_req), .link_in(link_in));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count transmit starts
  always @(posedge clk) begin
    if (tx_req.valid === 1'b1) tx_count <= tx_count + 1;
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("ERROR %0t watchdog", $time);
    finish_test();
  end
  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd32(a, rv);
    chk(rv, exp);
  endtask
  function automatic logic [7:0] pg(input logic [3:0] p, input logic [1:0] ep);
    return {p, ep, 2'b00};
  endfunction
  function automatic logic [31:0] cmd(input logic [1:0] ep, input logic i, input logic o,
                                      input logic [3:0] op, input logic [2:0] arg);
    return {17'h0, arg, op, 2'b00, o, i, 2'b00, ep};
  endfunction
  task automatic send(input logic [1:0] ep, input xfer_t xt);
    wr32(`OFS_CMD, cmd(ep, 1'b1, 1'b0, `OP_SEND, xt));
    chk(32'({tx_req.valid, tx_req.ep, tx_req.xfer}), 32'({1'b1, ep, xt}));
    @(posedge clk);
    #1;
    chk(32'(tx_req.valid), 32'h0);
  endtask
  task automatic wait_idle(input logic [1:0] ep);
    int n;
    n = 0;
    do begin
      rd32(`OFS_EPSTATE, rv);
      n++;
    end while (rv[24 + ep] !== 1'b0 && n < 40);
    chk(32'(rv[24 + ep]), 32'h0);
    if (rv[24 + ep] !== 1'b0) finish_test();
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    err_count = 0;
    compares = 0;
    tx_count = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(32'({ep_ctrl.stall_in, ep_ctrl.dma_in_en, ep_ctrl.device_mode}), 32'h0);
    rchk(`OFS_DMAMAP, 32'h0E79);
    rchk(8'hFC, 32'h0);
    // Host mode flags, masked and sticky
    u_usb_link_partner.flag_event(2'd2, 32'hFFFF_FFFF);
    rchk(pg(`PAGE_STAT, 2'd2), `HOST_MASK);
    u_usb_link_partner.flag_event(2'd0, 32'hFFFF_FFFF);
    repeat (10) @(posedge clk);
    rchk(pg(`PAGE_STAT, 2'd0), `HOST_EP0_MASK);
    wr32(pg(`PAGE_STAT, 2'd0), 32'hFFFF_FFFF);
    wr32(pg(`PAGE_STAT, 2'd2), 32'hFFFF_FFFF);
    // Device mode flags, partial clear by mask
    wr32(`OFS_CTRL, 32'h1);
    chk(32'(ep_ctrl.device_mode), 32'h1);
    u_usb_link_partner.flag_event(2'd3, 32'hFFFF_FFFF);
    rchk(pg(`PAGE_STAT, 2'd3), `DEV_MASK);
    u_usb_link_partner.flag_event(2'd0, 32'hFFFF_FFFF);
    rchk(pg(`PAGE_STAT, 2'd0), `DEV_EP0_MASK);
    wr32(pg(`PAGE_STAT, 2'd3), 32'h0005_0000);
    rchk(pg(`PAGE_STAT, 2'd3), 32'h03FA_0000);
    wr32(pg(`PAGE_STAT, 2'd3), rv);
    rchk(pg(`PAGE_STAT, 2'd3), 32'h0);
    // Stall per direction
    wr32(`OFS_CMD, cmd(2'd2, 1'b1, 1'b1, `OP_STALL_SET, 3'd0));
    wr32(`OFS_CMD, cmd(2'd2, 1'b1, 1'b0, `OP_STALL_CLR, 3'd0));
    chk(32'({ep_ctrl.stall_in, ep_ctrl.stall_out}), 32'h4);
    // DMA enable, disable with stray bits, channel map
    wr32(`OFS_CMD, cmd(2'd1, 1'b1, 1'b1, `OP_DMA_EN, 3'd2));
    chk(32'({ep_ctrl.dma_in_en, ep_ctrl.dma_out_en, ep_ctrl.dma_mode[1]}), 32'h8A);
    wr32(`OFS_CMD, cmd(2'd1, 1'b1, 1'b0, `OP_DMA_DIS, 3'd7) | 32'hFFFF_80CC);
    chk(32'({ep_ctrl.dma_in_en, ep_ctrl.dma_out_en}), 32'h2);
    wr32(`OFS_CMD, cmd(2'd3, 1'b0, 1'b1, `OP_DMA_MAP, 3'd1));
    wr32(`OFS_CMD, cmd(2'd1, 1'b1, 1'b0, `OP_DMA_MAP, 3'd2));
    wr32(`OFS_CMD, cmd(2'd0, 1'b0, 1'b1, `OP_DMA_MAP, 3'd0));
    wr32(`OFS_CMD, cmd(2'd2, 1'b0, 1'b1, `OP_DMA_MAP, 3'd3));
    rchk(`OFS_DMAMAP, 32'h067D);
    for (int e = 0; e < 4; e++) rchk(pg(`PAGE_FADDR, 2'(e)), 32'(`FIFO_PHYS_BASE + 4 * e));
    // All transfer types, then refusals while busy
    for (int t = 0; t < 5; t++) begin
      send(2'd1, xfer_t'(t));
      wait_idle(2'd1);
    end
    u_usb_link_partner.reply_delay = 30;
    send(2'd1, `XFER_DEVICE_IN);
    wr32(`OFS_CMD, cmd(2'd1, 1'b1, 1'b0, `OP_SEND, `XFER_DEVICE_IN));
    chk(32'(tx_req.valid), 32'h0);
    wr32(pg(`PAGE_DATA, 2'd1), 32'h5A);
    rchk(`OFS_RESULT, 32'h3);
    wait_idle(2'd1);
    // Toggle reset, endpoint zero left alone
    send(2'd1, `XFER_DEVICE_IN);
    wait_idle(2'd1);
    chk(32'(ep_ctrl.toggle_in[1]), 32'h1);
    wr32(`OFS_CMD, cmd(2'd1, 1'b1, 1'b0, `OP_TOGGLE_CLR, 3'd0));
    chk(32'(ep_ctrl.toggle_in[1]), 32'h0);
    u_usb_link_partner.rx_packet(2'd0, 13'h0);
    wr32(`OFS_CMD, cmd(2'd0, 1'b0, 1'b1, `OP_TOGGLE_CLR, 3'd0));
    chk(32'(ep_ctrl.toggle_out[0]), 32'h1);
    // Auto transmit on the 64th byte only
    wr32(`OFS_AUTO, 32'h42);
    n0 = tx_count;
    for (int i = 0; i < 63; i++) wr32(pg(`PAGE_DATA, 2'd1), 32'(i));
    chk(32'(tx_count - n0), 32'h0);
    wr32(pg(`PAGE_DATA, 2'd1), 32'h3F);
    chk(32'({tx_req.valid, tx_req.ep, tx_req.xfer}), 32'({1'b1, 2'd1, `XFER_DEVICE_IN}));
    wait_idle(2'd1);
    // Endpoint zero holds 64 bytes
    for (int i = 0; i < 64; i++) wr32(pg(`PAGE_DATA, 2'd0), 32'(i));
    rd32(`OFS_RESULT, rv);
    chk(32'(rv[1]), 32'h0);
    wr32(pg(`PAGE_DATA, 2'd0), 32'hFF);
    rd32(`OFS_RESULT, rv);
    chk(32'(rv[1]), 32'h1);
    // Receive counts, zero-length packet, auto clear
    rchk(pg(`PAGE_AVAIL, 2'd3), 32'h0);
    u_usb_link_partner.rx_packet(2'd3, 13'h0);
    rchk(pg(`PAGE_AVAIL, 2'd3), 32'h0001_0000);
    u_usb_link_partner.rx_packet(2'd2, 13'h5);
    rchk(pg(`PAGE_AVAIL, 2'd2), 32'h0001_0005);
    for (int i = 0; i < 4; i++) rd32(pg(`PAGE_DATA, 2'd2), rv);
    rchk(pg(`PAGE_AVAIL, 2'd2), 32'h0001_0001);
    rd32(pg(`PAGE_DATA, 2'd2), rv);
    rchk(pg(`PAGE_AVAIL, 2'd2), 32'h0);
    // Mid-run reset restores defaults
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(32'({ep_ctrl.device_mode, ep_ctrl.dma_out_en}), 32'h0);
    rchk(`OFS_DMAMAP, 32'h0E79);
    finish_test();
  end
endmodule // tb
